// [common/pslc_pkg.sv]
// Shared constants for the power state and load switch controller
package pslc_pkg;
	// Register offsets
	localparam logic [7:0] CHANNEL_ENABLE_REG_ADDR = 8'h05;
	localparam logic [7:0] REGULATOR_CONTROL_REG_ADDR = 8'h22;
	// Field positions
	localparam int SW_ONE_EN_BIT = 4;
	localparam int SW_TWO_EN_BIT = 5;
	localparam int FORCE_ON_BIT = 0;
	localparam int REG_TWO_SEL_LO = 4;
	localparam int REG_TWO_SEL_HI = 5;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SW_TWO_LIMIT_US = 1000;
	localparam int SW_TWO_LIMIT_CYC = SW_TWO_LIMIT_US * 1000 / CLK_PERIOD_NS;
	localparam int SW_ONE_START_US = 1000;
	localparam int SW_ONE_START_CYC = SW_ONE_START_US * 1000 / CLK_PERIOD_NS;
	localparam int SPIKE_NS = 50;
	localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Regulator one targets in millivolts
	localparam logic [15:0] REG_ONE_BATT_MV = 16'h12C0;
	localparam logic [15:0] REG_ONE_CH1_MV = 16'h1388;
	// Regulator two output base and step in millivolts
	localparam logic [15:0] REG_TWO_BASE_MV = 16'h0C30;
	localparam logic [15:0] REG_TWO_STEP_MV = 16'h0032;
	// Operating states
	typedef enum logic [1:0] {
		PSLC_OFF = 2'b00,
		PSLC_STANDBY = 2'b01,
		PSLC_SEQ_UP = 2'b10,
		PSLC_POWERED = 2'b11
	} pslc_state_e;
endpackage : pslc_pkg

// [hw/pslc_top.sv]
// Operating state control and always-on regulator load switch control
//
// Behaviour
// - Both always-on regulators stay permanently enabled
// - Regulator one source and target follow channel one
// - Enable bit four drives switch one
// - Switch one limits when regulator one sags
// - Switch one start-up uses 70 mA limit
// - Force-on removes limit, ignores enable pin
// - Channel one fault turns switch one off
// - Control field selects regulator two voltage
// - No fault flag for regulator two
// - Enable bit five drives switch two
// - Switch two limited 1 ms each enable
// - Channel three fault turns switch two off
// - Lockout release loads defaults, enters standby
// - Enable pin starts sequencer, powered at last
// - Enable low powers down to standby
// - Lower lockout shuts all channels down
// - After lockout, enable must toggle to restart
// - Lockout resets registers; only regulators stay
// - Driver lockout overrides battery when channel off
// - Defaults from OTP, all registers writable
// - I2C spikes under 50 ns filtered out
// - Switch one sequenced only without force-on
`timescale 1ns/10ps
module pslc_top #(
	parameter int SW_TWO_LIMIT_CYCLES = pslc_pkg::SW_TWO_LIMIT_CYC,
	parameter int SW_ONE_START_CYCLES = pslc_pkg::SW_ONE_START_CYC,
	parameter int SEQ_LAST_CYCLES = 16
) (
	input wire logic ref_clk, // 100 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic enable_pin, // Global enable pin, async
	input wire logic battery_above_upper, // Battery above upper lockout, async
	input wire logic battery_above_lower, // Battery above lower lockout, async
	input wire logic driver_supply_ok, // Driver supply above 3.5 V, async
	input wire logic ch1_above_switchover, // Channel one above switch-over, async
	input wire logic ch1_enabled, // Channel one enable from sequencer logic
	input wire logic ch1_fault_shutdown, // Channel one OV/SC shutdown
	input wire logic ch3_fault_shutdown, // Channel three OV/SC shutdown
	input wire logic reg_one_below_4v5, // Regulator one below 4.5 V, async
	input wire logic [7:0] otp_channel_enable, // OTP default for 0x05
	input wire logic [7:0] otp_regulator_control, // OTP default for 0x22
	input wire logic scl_in, // I2C clock pin
	input wire logic sda_in, // I2C data pin
	input wire logic wr_en, // Register write strobe from I2C engine
	input wire logic [7:0] wr_addr, // Register write address
	input wire logic [7:0] wr_data, // Register write data
	input wire logic [7:0] rd_addr, // Register read address
	output logic [7:0] rd_data, // Register read data
	output logic scl_filt, // Filtered I2C clock
	output logic sda_filt, // Filtered I2C data
	output logic i2c_active, // I2C interface enabled
	output logic [1:0] op_state, // Operating state
	output logic powerup_start, // Pulse: start power-up sequencer
	output logic powerdown_start, // Pulse: start power-down sequencer
	output logic all_channels_off, // Lockout shutdown incl. current sense
	output logic reg_one_on, // Always-on regulator one enable
	output logic reg_two_on, // Always-on regulator two enable
	output logic reg_one_from_ch1, // Regulator one fed from channel one
	output logic [15:0] reg_one_target_mv, // Regulator one target
	output logic [15:0] reg_two_target_mv, // Regulator two target
	output logic load_switch_one, // Switch one on
	output logic sw_one_limit, // Switch one current limit active
	output logic sw_one_startup_limit, // Switch one 70 mA start-up limit
	output logic load_switch_two, // Switch two on
	output logic sw_two_limit // Switch two fixed current limit
);
	////////////////////////////////////////////////////////////////////////////////
	// Synchronisers
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	assign async_in = {sda_in, scl_in, reg_one_below_4v5, ch1_above_switchover,
		driver_supply_ok, battery_above_lower, battery_above_upper};
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= async_in;
			sync_b <= sync_a;
		end
	end
	logic upper_ok;
	logic lower_ok;
	logic vdr_ok;
	logic sw_over;
	logic below_4v5;
	assign upper_ok = sync_b[0];
	assign lower_ok = sync_b[1];
	assign vdr_ok = sync_b[2];
	assign sw_over = sync_b[3];
	assign below_4v5 = sync_b[4];
	logic en_a;
	logic en_s;
	logic en_d;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			en_a <= 1'b0;
			en_s <= 1'b0;
			en_d <= 1'b0;
		end else begin
			en_a <= enable_pin;
			en_s <= en_a;
			en_d <= en_s;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// I2C spike filter: a level is accepted only after it holds for longer than the spike time
	logic [1:0] filt;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_spk
			logic [3:0] cnt;
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					cnt <= 4'h0;
					filt[gi] <= 1'b1;
				end else if (sync_b[5+gi] == filt[gi]) begin
					cnt <= 4'h0;
				end else if (cnt >= 4'(pslc_pkg::SPIKE_CYC)) begin
					filt[gi] <= sync_b[5+gi];
					cnt <= 4'h0;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	endgenerate
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_filt <= 1'b1;
			sda_filt <= 1'b1;
		end else begin
			scl_filt <= filt[0];
			sda_filt <= filt[1];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Lockout: driver supply lockout wins when channel one is off
	logic locked;
	logic upper_eff;
	assign locked = !lower_ok || (!ch1_enabled && !vdr_ok);
	assign upper_eff = upper_ok && (ch1_enabled || vdr_ok);
	////////////////////////////////////////////////////////////////////////////////
	// Operating state machine
	pslc_pkg::pslc_state_e state;
	logic need_toggle;
	logic [7:0] seq_cnt;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= pslc_pkg::PSLC_OFF;
			need_toggle <= 1'b0;
			seq_cnt <= 8'h00;
		end else if (locked && state != pslc_pkg::PSLC_OFF) begin
			state <= pslc_pkg::PSLC_OFF;
			need_toggle <= 1'b1;
		end else begin
			if (!en_s) begin
				need_toggle <= 1'b0;
			end
			unique case (state)
				pslc_pkg::PSLC_OFF: begin
					if (upper_eff) begin
						state <= pslc_pkg::PSLC_STANDBY;
					end
				end
				pslc_pkg::PSLC_STANDBY: begin
					if (en_s && !en_d && !need_toggle) begin
						state <= pslc_pkg::PSLC_SEQ_UP;
						seq_cnt <= 8'h00;
					end
				end
				pslc_pkg::PSLC_SEQ_UP: begin
					if (!en_s) begin
						state <= pslc_pkg::PSLC_STANDBY;
					end else if (seq_cnt >= 8'(SEQ_LAST_CYCLES - 1)) begin
						state <= pslc_pkg::PSLC_POWERED;
					end else begin
						seq_cnt <= seq_cnt + 8'h01;
					end
				end
				pslc_pkg::PSLC_POWERED: begin
					if (!en_s) begin
						state <= pslc_pkg::PSLC_STANDBY;
					end
				end
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			op_state <= 2'b00;
			powerup_start <= 1'b0;
			powerdown_start <= 1'b0;
			all_channels_off <= 1'b1;
			i2c_active <= 1'b0;
		end else begin
			op_state <= (state == pslc_pkg::PSLC_SEQ_UP) ? 2'b01 : state;
			powerup_start <= state == pslc_pkg::PSLC_STANDBY && en_s && !en_d
				&& !need_toggle && !locked;
			powerdown_start <= !en_s && en_d && state != pslc_pkg::PSLC_OFF
				&& !locked;
			all_channels_off <= state == pslc_pkg::PSLC_OFF;
			i2c_active <= state != pslc_pkg::PSLC_OFF;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Registers: OTP defaults reloaded while off, writable once active
	logic [7:0] channel_enable_reg;
	logic [7:0] regulator_control_reg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			channel_enable_reg <= 8'h00;
			regulator_control_reg <= 8'h00;
		end else if (state == pslc_pkg::PSLC_OFF) begin
			channel_enable_reg <= otp_channel_enable;
			regulator_control_reg <= otp_regulator_control;
		end else if (wr_en) begin
			if (wr_addr == pslc_pkg::CHANNEL_ENABLE_REG_ADDR) begin
				channel_enable_reg <= wr_data;
			end
			if (wr_addr == pslc_pkg::REGULATOR_CONTROL_REG_ADDR) begin
				regulator_control_reg <= wr_data;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else if (rd_addr == pslc_pkg::CHANNEL_ENABLE_REG_ADDR) begin
			rd_data <= channel_enable_reg;
		end else if (rd_addr == pslc_pkg::REGULATOR_CONTROL_REG_ADDR) begin
			rd_data <= regulator_control_reg;
		end else begin
			rd_data <= 8'h00;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Always-on regulators
	logic [1:0] reg_two_sel;
	assign reg_two_sel = regulator_control_reg[pslc_pkg::REG_TWO_SEL_HI:pslc_pkg::REG_TWO_SEL_LO];
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_one_on <= 1'b1;
			reg_two_on <= 1'b1;
			reg_one_from_ch1 <= 1'b0;
			reg_one_target_mv <= pslc_pkg::REG_ONE_BATT_MV;
			reg_two_target_mv <= pslc_pkg::REG_TWO_BASE_MV;
		end else begin
			reg_one_on <= 1'b1;
			reg_two_on <= 1'b1;
			reg_one_from_ch1 <= ch1_enabled && sw_over;
			reg_one_target_mv <= (ch1_enabled && sw_over) ? pslc_pkg::REG_ONE_CH1_MV
				: pslc_pkg::REG_ONE_BATT_MV;
			reg_two_target_mv <= pslc_pkg::REG_TWO_BASE_MV
				+ pslc_pkg::REG_TWO_STEP_MV * {14'h0000, reg_two_sel};
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Load switches
	logic force_on;
	logic sw_one_req;
	logic sw_two_req;
	logic sw_one_q;
	logic sw_two_q;
	logic [19:0] one_cnt;
	logic [19:0] two_cnt;
	assign force_on = regulator_control_reg[pslc_pkg::FORCE_ON_BIT];
	// Sequenced switch one obeys the enable pin; force-on does not
	// Off state wins over force-on: only the regulators may stay up in lockout
	assign sw_one_req = channel_enable_reg[pslc_pkg::SW_ONE_EN_BIT] && !ch1_fault_shutdown
		&& state != pslc_pkg::PSLC_OFF
		&& (force_on || state == pslc_pkg::PSLC_POWERED
		|| state == pslc_pkg::PSLC_SEQ_UP);
	assign sw_two_req = channel_enable_reg[pslc_pkg::SW_TWO_EN_BIT] && !ch3_fault_shutdown
		&& state != pslc_pkg::PSLC_OFF;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sw_one_q <= 1'b0;
			sw_two_q <= 1'b0;
			one_cnt <= 20'h00000;
			two_cnt <= 20'h00000;
		end else begin
			sw_one_q <= sw_one_req;
			sw_two_q <= sw_two_req;
			if (sw_one_req && !sw_one_q) begin
				one_cnt <= 20'(SW_ONE_START_CYCLES);
			end else if (one_cnt != 20'h00000) begin
				one_cnt <= one_cnt - 20'h00001;
			end
			if (sw_two_req && !sw_two_q) begin
				two_cnt <= 20'(SW_TWO_LIMIT_CYCLES);
			end else if (two_cnt != 20'h00000) begin
				two_cnt <= two_cnt - 20'h00001;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			load_switch_one <= 1'b0;
			load_switch_two <= 1'b0;
			sw_one_limit <= 1'b0;
			sw_one_startup_limit <= 1'b0;
			sw_two_limit <= 1'b0;
		end else begin
			load_switch_one <= sw_one_req;
			load_switch_two <= sw_two_req;
			sw_one_limit <= sw_one_req && !force_on && below_4v5;
			sw_one_startup_limit <= sw_one_req && !force_on
				&& (one_cnt != 20'h00000 || (sw_one_req && !sw_one_q));
			sw_two_limit <= sw_two_req && (two_cnt != 20'h00000 || !sw_two_q);
		end
	end
endmodule : pslc_top

// [bench/pslc_properties.sv]
// Assertion checker for the power state and load switch controller
`timescale 1ns/10ps
module pslc_properties (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Reset
	input wire logic enable_pin, // Enable pin
	input wire logic ch1_fault_shutdown, // Channel one fault
	input wire logic ch3_fault_shutdown, // Channel three fault
	input wire logic [1:0] op_state, // State
	input wire logic powerup_start, // Up pulse
	input wire logic powerdown_start, // Down pulse
	input wire logic reg_one_on, // Regulator one on
	input wire logic reg_two_on, // Regulator two on
	input wire logic reg_one_from_ch1, // Regulator one source
	input wire logic [15:0] reg_one_target_mv, // Regulator one target
	input wire logic load_switch_one, // Switch one
	input wire logic load_switch_two, // Switch two
	input wire logic sw_two_limit, // Switch two limit
	input wire logic all_channels_off, // Lockout shutdown
	input wire logic i2c_active // I2C enabled
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Pin must stay high, else powering up is legally abandoned
	sequence s_held_up;
		powerup_start ##1 enable_pin [*8];
	endsequence
	sequence s_powered;
		##[4:12] op_state == 2'b11;
	endsequence
	////////////////////////////////////////////////////////////////
	AST_REGS_ON: assert property (reg_one_on && reg_two_on)
		else $error("always-on regulator disabled");
	AST_REG_ONE_TARGET: assert property (reg_one_target_mv ==
		(reg_one_from_ch1 ? 16'h1388 : 16'h12C0)) else $error("regulator one target wrong");
	AST_SW_ONE_FAULT: assert property (ch1_fault_shutdown |=> !load_switch_one)
		else $error("switch one on after channel one fault");
	AST_SW_TWO_FAULT: assert property (ch3_fault_shutdown |=> !load_switch_two)
		else $error("switch two on after channel three fault");
	AST_SW_TWO_LIMIT: assert property ($rose(load_switch_two) |-> ##[0:1] sw_two_limit)
		else $error("switch two enabled without limit");
	AST_POWERED: assert property (s_held_up |-> s_powered)
		else $error("powered state not reached");
	AST_POWER_DOWN: assert property ($fell(enable_pin) && op_state == 2'b11
		|-> ##[1:6] powerdown_start) else $error("no power-down start");
	AST_OFF_QUIET: assert property (all_channels_off
		|-> !i2c_active && !load_switch_one && !load_switch_two) else $error("activity while off");
endmodule : pslc_properties
////////////////////////////////////////////////////////////////
bind pslc_top pslc_properties u_props (.ref_clk, .rst, .enable_pin, .ch1_fault_shutdown,
	.ch3_fault_shutdown, .op_state, .powerup_start, .powerdown_start, .reg_one_on,
	.reg_two_on, .reg_one_from_ch1, .reg_one_target_mv, .load_switch_one,
	.load_switch_two, .sw_two_limit, .all_channels_off, .i2c_active);

// [bench/pslc_host_model.sv]
// Host model driving the enable pin and the register write and read ports
`timescale 1ns/10ps
module pslc_host_model (
	input wire logic ref_clk, // Clock
	output logic enable_pin, // Enable pin
	output logic wr_en, // Write strobe
	output logic [7:0] wr_addr, // Write address
	output logic [7:0] wr_data, // Write data
	output logic [7:0] rd_addr // Read address
);
	initial begin
		enable_pin = 1'b0;
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_addr = 8'h00;
	end
	// Enable bits are set before the pin rises, switch two once its supply is up
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(negedge ref_clk);
		wr_en <= 1'b0;
		wr_addr <= ~a;
		wr_data <= ~d;
	endtask : wr
	// Restart after lockout needs a low then high level
	task pin(input logic v);
		@(negedge ref_clk);
		enable_pin <= v;
	endtask : pin
	task rd(input logic [7:0] a);
		@(negedge ref_clk);
		rd_addr <= a;
	endtask : rd
endmodule : pslc_host_model

// [bench/pslc_top_tb.sv]
// Self-checking testbench for the power state and load switch controller
`timescale 1ns/10ps
module pslc_top_tb;
	logic ref_clk = 1'b0, rst = 1'b1, enable_pin, bat_up, bat_lo;
	logic drv_ok, ch1_sw, ch1_en, f1, f3, low45;
	logic scl_in, sda_in, wr_en, look = 1'b0;
	logic [7:0] otp_ce, otp_rc, wr_addr, wr_data, rd_addr, rd_data;
	logic scl_filt, sda_filt, i2c_act, pu, pd, aco, r1on, r2on, r1ch1, sw1, sw1l, sw1s, sw2, sw2l;
	logic [1:0] op_state;
	logic [15:0] t1, t2, e;
	logic [15:0] q_exp[$];
	int q_sel[$];
	int s, miscompares = 0, compares = 0;
	always #5 ref_clk = ~ref_clk;
	pslc_host_model host (.ref_clk(ref_clk), .enable_pin(enable_pin), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr));
	pslc_top #(.SW_TWO_LIMIT_CYCLES(20), .SW_ONE_START_CYCLES(20)) dut (.ref_clk(ref_clk),
		.rst(rst), .enable_pin(enable_pin), .battery_above_upper(bat_up),
		.battery_above_lower(bat_lo), .driver_supply_ok(drv_ok), .ch1_above_switchover(ch1_sw),
		.ch1_enabled(ch1_en), .ch1_fault_shutdown(f1), .ch3_fault_shutdown(f3),
		.reg_one_below_4v5(low45), .otp_channel_enable(otp_ce), .otp_regulator_control(otp_rc),
		.scl_in(scl_in), .sda_in(sda_in), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_addr(rd_addr), .rd_data(rd_data), .scl_filt(scl_filt), .sda_filt(sda_filt),
		.i2c_active(i2c_act), .op_state(op_state), .powerup_start(pu), .powerdown_start(pd),
		.all_channels_off(aco), .reg_one_on(r1on), .reg_two_on(r2on), .reg_one_from_ch1(r1ch1),
		.reg_one_target_mv(t1), .reg_two_target_mv(t2), .load_switch_one(sw1),
		.sw_one_limit(sw1l), .sw_one_startup_limit(sw1s), .load_switch_two(sw2),
		.sw_two_limit(sw2l));
	////////////////////////////////////////////////////////////////
	function logic [15:0] obs(input int k);
		case (k)
			0: obs = 16'(rd_data);
			1: obs = 16'(op_state);
			2: obs = 16'(sw1);
			3: obs = 16'(sw2);
			4: obs = 16'(sw2l);
			5: obs = 16'(sw1l);
			6: obs = 16'(scl_filt);
			7: obs = t2;
			8: obs = t1;
			9: obs = 16'(aco);
			10: obs = 16'(sw1s);
			11: obs = 16'(sda_filt);
			default: obs = 16'(i2c_act);
		endcase
	endfunction : obs
	function string oname(input int k);
		case (k)
			0: oname = "rd_data";
			1: oname = "op_state";
			2: oname = "load_switch_one";
			3: oname = "load_switch_two";
			4: oname = "sw_two_limit";
			5: oname = "sw_one_limit";
			6: oname = "scl_filt";
			7: oname = "reg_two_target_mv";
			8: oname = "reg_one_target_mv";
			9: oname = "all_channels_off";
			10: oname = "sw_one_startup_limit";
			11: oname = "sda_filt";
			default: oname = "i2c_active";
		endcase
	endfunction : oname
	task ck(input int k, input logic [15:0] v);
		q_sel.push_back(k);
		q_exp.push_back(v);
		look <= 1'b1;
		@(negedge ref_clk);
		look <= 1'b0;
		@(negedge ref_clk);
	endtask : ck
	task w(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : w
	task tally_and_finish;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	// Results are judged half a cycle after the edge, once outputs have settled
	always @(negedge ref_clk) begin
		if (look) begin
			s = q_sel.pop_front();
			e = q_exp.pop_front();
			compares++;
			if (obs(s) !== e) begin
				miscompares++;
				$display("FAIL %s expected %h seen %h", oname(s), e, obs(s));
			end
		end
	end
	initial begin
		#150000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(45307));
		{bat_up, bat_lo, drv_ok, scl_in, sda_in} = 5'h1F;
		{ch1_sw, ch1_en, f1, f3, low45} = 5'h00;
		otp_ce = 8'($urandom) & 8'hCE;
		otp_rc = 8'($urandom) & 8'hCE;
		w(2);
		ck(1, 16'h0000);
		ck(9, 16'h0001);
		rst <= 1'b0;
		w(10);
		ck(1, 16'h0001);
		ck(12, 16'h0001);
		host.rd(8'h05);
		ck(0, 16'(otp_ce));
		host.rd(8'h33);
		ck(0, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			host.wr(8'h22, 8'(i << 4));
			w(3);
			ck(7, 16'h0C30 + 16'h0032 * 16'(i));
			host.rd(8'h22);
			ck(0, 16'(i << 4));
		end
		$display("test registers done");
		host.wr(8'h05, 8'h20);
		w(2);
		ck(3, 16'h0001);
		ck(4, 16'h0001);
		w(20);
		ck(4, 16'h0000);
		f3 <= 1'b1;
		w(2);
		ck(3, 16'h0000);
		f3 <= 1'b0;
		low45 <= 1'b1;
		host.wr(8'h22, 8'h01);
		host.wr(8'h05, 8'h10);
		w(4);
		ck(2, 16'h0001);
		ck(5, 16'h0000);
		f1 <= 1'b1;
		w(2);
		ck(2, 16'h0000);
		f1 <= 1'b0;
		host.wr(8'h22, 8'h00);
		w(3);
		ck(2, 16'h0000);
		$display("test switches done");
		host.pin(1'b1);
		w(8);
		ck(10, 16'h0001);
		w(20);
		ck(1, 16'h0003);
		ck(2, 16'h0001);
		ck(5, 16'h0001);
		ck(10, 16'h0000);
		low45 <= 1'b0;
		host.pin(1'b0);
		w(8);
		ck(1, 16'h0001);
		ck(2, 16'h0000);
		ch1_en <= 1'b1;
		ch1_sw <= 1'b1;
		w(5);
		ck(8, 16'h1388);
		ch1_sw <= 1'b0;
		w(5);
		ck(8, 16'h12C0);
		$display("test power modes done");
		host.pin(1'b1);
		w(30);
		bat_lo <= 1'b0;
		bat_up <= 1'b0;
		w(6);
		ck(1, 16'h0000);
		ck(9, 16'h0001);
		ck(12, 16'h0000);
		bat_lo <= 1'b1;
		w(6);
		ck(1, 16'h0000);
		bat_up <= 1'b1;
		w(30);
		ck(1, 16'h0001);
		host.rd(8'h05);
		ck(0, 16'(otp_ce));
		host.pin(1'b0);
		w(6);
		host.pin(1'b1);
		w(30);
		ck(1, 16'h0003);
		host.pin(1'b0);
		w(6);
		ch1_en <= 1'b0;
		drv_ok <= 1'b0;
		w(6);
		ck(1, 16'h0000);
		drv_ok <= 1'b1;
		$display("test lockout done");
		scl_in <= 1'b0;
		w(2);
		scl_in <= 1'b1;
		w(3);
		ck(6, 16'h0001);
		scl_in <= 1'b0;
		sda_in <= 1'b0;
		w(12);
		ck(6, 16'h0000);
		ck(11, 16'h0000);
		$display("test filter done");
		tally_and_finish;
	end
endmodule : pslc_top_tb
